// file: design/flash_cfg_pkg.sv
// Purpose: shared constants for the flash read-setup word and its bus
// Assumes: one 250 MHz clock, pins sampled synchronously on clk_i
// Notes: host command port map sits at the end
package flash_cfg_pkg;

  // Read-setup word layout
  localparam int PROTO_BIT = 15;
  localparam int RES14_BIT = 14;
  localparam int LAT_HI = 13;
  localparam int LAT_LO = 11;
  localparam int WAIT_POL_BIT = 10;
  localparam int HOLD_BIT = 9;
  localparam int WAIT_EARLY_BIT = 8;
  localparam int ORDER_BIT = 7;
  localparam int EDGE_BIT = 6;
  localparam int RES5_BIT = 5;
  localparam int RES4_BIT = 4;
  localparam int WRAP_BIT = 3;
  localparam int BLEN_HI = 2;
  localparam int BLEN_LO = 0;
  localparam logic [15:0] SETUP_RESET = 16'hBFCF;

  // Field codes
  localparam logic [2:0] LAT_MIN = 3'h2;
  localparam logic [2:0] BLEN_4 = 3'h1;
  localparam logic [2:0] BLEN_8 = 3'h2;
  localparam logic [2:0] BLEN_16 = 3'h3;
  localparam logic [2:0] BLEN_CONT = 3'h7;

  // Device commands on the low data byte
  localparam logic [7:0] CMD_SETUP_PREP = 8'h60;
  localparam logic [7:0] CMD_SETUP_LOAD = 8'h03;
  localparam logic [7:0] CMD_READ_IDENT = 8'h90;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hFF;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [15:0] IDENT_SETUP_OFFSET = 16'h0005;

  // Host: cycles from read start to data sample
  localparam logic [3:0] READ_WAIT_CYC = 4'hA;

  // Host command port (Wishbone byte addresses)
  localparam logic [7:0] HOST_ADDR_OFF = 8'h00;
  localparam logic [7:0] HOST_WDATA_OFF = 8'h04;
  localparam logic [7:0] HOST_RDATA_OFF = 8'h08;
  localparam logic [7:0] HOST_CTRL_OFF = 8'h0C;
  localparam logic [7:0] HOST_STATUS_OFF = 8'h10;

  typedef enum logic [1:0] {OP_WRITE, OP_READ, OP_CONFIG, OP_READ_SETUP} op_e;

endpackage : flash_cfg_pkg

// file: design/flash_bus_if.sv
// Purpose: pins between flash controller and flash device
// Assumes: both ends on the same clk_i
// Notes: resolves the shared data bus and wait line from enables
`timescale 1ns/1ps
interface flash_bus_if;
  logic [15:0] addr;
  logic ce_n;
  logic oe_n;
  logic we_n;
  logic address_latch_strobe_n;
  logic [15:0] dq_host;
  logic dq_host_oe;
  logic [15:0] dq_dev;
  logic dq_dev_oe;
  logic [15:0] dq;
  logic wait_dev;
  logic wait_oe;
  logic wait_line;

  // Undriven bus floats high, undriven wait reads low
  assign dq = dq_dev_oe ? dq_dev : (dq_host_oe ? dq_host : 16'hFFFF);
  assign wait_line = wait_oe ? wait_dev : 1'b0;

  modport dev (
    input addr, ce_n, oe_n, we_n, address_latch_strobe_n, dq,
    output dq_dev, dq_dev_oe, wait_dev, wait_oe
  );
  modport host (
    output addr, ce_n, oe_n, we_n, address_latch_strobe_n, dq_host,
    output dq_host_oe,
    input dq, wait_line
  );
endinterface : flash_bus_if

// file: design/flash_setup_dev.sv
// Purpose: flash device end holding the read-setup word and read timing
// Assumes: pins synchronous to clk_i; rst_i is the device reset pin
// Notes: array contents are not stored; an array word reads as its address
// What this block does
// - Top bit picks burst or page reads
// - Only setup command pair changes word
// - Identifier offset five returns setup word
// - Bits 13..11 give first-access latency code
// - Bit 10 sets wait output active level
// - Bit 7 linear order only
// - Bit 6 names active clock edge, only reported outward
// - Bit 3 clear enables wrap within length
// - Bits 2..0 give burst length
// - Host clears reserved bits when loading
// - Code 2, long hold forbids early wait
// - Latency counts clocks latch to data
// - Bit 9 holds each word two clocks
// - Bit 8 ends wait one cycle early
`timescale 1ns/1ps
module flash_setup_dev
  import flash_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  flash_bus_if.dev bus,
  output logic [15:0] read_setup_o,
  output logic seq_error_o,
  output logic ident_mode_o,
  output logic active_edge_o
);

  typedef enum logic [1:0] {ST_ARRAY, ST_IDENT, ST_PREP} cmd_state_e;

  cmd_state_e cmd_state_q;
  logic [15:0] setup_q;
  logic we_prev_q;
  logic seq_err_q;
  logic burst_q;
  logic [2:0] lat_q;
  logic hold_q;
  logic [15:0] baddr_q;
  logic [15:0] dq_q;
  logic write_strobe;
  logic read_active;
  logic latch;
  logic sync_mode;
  logic [7:0] cmd;
  logic [2:0] wait_thresh;
  logic wait_active;
  logic step;
  logic [15:0] next_baddr;

  // Latency code, reserved low codes run as the shortest legal one, code 2
  function automatic logic [2:0] lat_code(input logic [15:0] s);
    logic [2:0] c;
    c = s[LAT_HI:LAT_LO];
    if (c < LAT_MIN)
    begin
      c = LAT_MIN;
    end
    return c;
  endfunction : lat_code

  // Next linear burst address, wrapping inside a fixed length if asked
  function automatic logic [15:0] next_addr(input logic [15:0] a,
                                            input logic [15:0] s);
    logic [15:0] mask;
    logic [15:0] inc;
    mask = 16'hFFFF;
    inc = a + 16'h0001;
    if (s[BLEN_HI:BLEN_LO] == BLEN_4)
    begin
      mask = 16'h0003;
    end
    else if (s[BLEN_HI:BLEN_LO] == BLEN_8)
    begin
      mask = 16'h0007;
    end
    else if (s[BLEN_HI:BLEN_LO] == BLEN_16)
    begin
      mask = 16'h000F;
    end
    // Reserved length codes behave as continuous
    if (!s[WRAP_BIT] && mask != 16'hFFFF)
    begin
      return (a & ~mask) | (inc & mask);
    end
    return inc;
  endfunction : next_addr

  // Word driven for an address in the current read state
  function automatic logic [15:0] read_word(input cmd_state_e st,
                                            input logic [15:0] a,
                                            input logic [15:0] s);
    if (st == ST_IDENT)
    begin
      return (a == IDENT_SETUP_OFFSET) ? s : 16'h0000;
    end
    return a;
  endfunction : read_word

  // Pin decode
  assign write_strobe = !bus.ce_n && !bus.we_n && we_prev_q;
  assign read_active = !bus.ce_n && !bus.oe_n && bus.we_n;
  assign latch = !bus.ce_n && !bus.address_latch_strobe_n && bus.we_n;
  assign sync_mode = !setup_q[PROTO_BIT];
  assign cmd = bus.dq[7:0];
  assign next_baddr = next_addr(baddr_q, setup_q);

  // One write per falling write-enable, so a held low is one command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      we_prev_q <= 1'b1;
    end
    else
    begin
      we_prev_q <= bus.we_n;
    end
  end

  // Command state and the setup word itself
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_state_q <= ST_ARRAY;
      setup_q <= SETUP_RESET;
    end
    else if (write_strobe)
    begin
      if (cmd_state_q == ST_PREP)
      begin
        // Address lines carry the new word; any other byte aborts
        if (cmd == CMD_SETUP_LOAD)
        begin
          setup_q <= bus.addr;
        end
        cmd_state_q <= ST_ARRAY;
      end
      else if (cmd == CMD_SETUP_PREP)
      begin
        cmd_state_q <= ST_PREP;
      end
      else if (cmd == CMD_READ_IDENT)
      begin
        cmd_state_q <= ST_IDENT;
      end
      else if (cmd == CMD_READ_ARRAY)
      begin
        cmd_state_q <= ST_ARRAY;
      end
    end
  end

  // Sequence error: a broken setup pair, cleared by its own command
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      seq_err_q <= 1'b0;
    end
    else if (write_strobe && cmd_state_q == ST_PREP && cmd != CMD_SETUP_LOAD)
    begin
      seq_err_q <= 1'b1;
    end
    else if (write_strobe && cmd_state_q != ST_PREP &&
             cmd == CMD_CLEAR_STATUS)
    begin
      seq_err_q <= 1'b0;
    end
  end

  // Data cycle step: with long hold a word advances every second clock
  assign step = setup_q[HOLD_BIT] ? hold_q : 1'b1;

  // Burst sequencer: latch, latency countdown, then data cycles
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      burst_q <= 1'b0;
      lat_q <= 3'h0;
      hold_q <= 1'b0;
      baddr_q <= 16'h0000;
    end
    else if (bus.ce_n || !sync_mode)
    begin
      burst_q <= 1'b0;
      lat_q <= 3'h0;
      hold_q <= 1'b0;
    end
    else if (latch)
    begin
      // A new latch restarts the burst from the given address
      burst_q <= 1'b1;
      lat_q <= lat_code(setup_q);
      hold_q <= 1'b0;
      baddr_q <= bus.addr;
    end
    else if (burst_q)
    begin
      if (lat_q != 3'h0)
      begin
        lat_q <= lat_q - 3'h1;
      end
      else
      begin
        hold_q <= setup_q[HOLD_BIT] ? !hold_q : 1'b0;
        // Non-array reads repeat the same word for the whole burst
        if (step && cmd_state_q == ST_ARRAY)
        begin
          baddr_q <= next_baddr;
        end
      end
    end
  end

  // Output data register: page reads follow the address every clock
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      dq_q <= 16'h0000;
    end
    else if (!sync_mode)
    begin
      dq_q <= read_word(cmd_state_q, bus.addr, setup_q);
    end
    else if (burst_q && !latch && !bus.ce_n)
    begin
      if (lat_q == 3'h1)
      begin
        dq_q <= read_word(cmd_state_q, baddr_q, setup_q);
      end
      else if (lat_q == 3'h0 && step && cmd_state_q == ST_ARRAY)
      begin
        dq_q <= read_word(cmd_state_q, next_baddr, setup_q);
      end
    end
  end

  // Early wait end: one data cycle (one or two clocks) before data
  always_comb
  begin
    wait_thresh = 3'h0;
    if (setup_q[WAIT_EARLY_BIT])
    begin
      wait_thresh = setup_q[HOLD_BIT] ? 3'h2 : 3'h1;
    end
  end
  assign wait_active = burst_q && (lat_q > wait_thresh);

  // Wait pin: polarity from the word, floats unless the read is on
  assign bus.wait_dev = wait_active ? setup_q[WAIT_POL_BIT]
                                    : !setup_q[WAIT_POL_BIT];
  assign bus.wait_oe = !bus.ce_n && !bus.oe_n;
  assign bus.dq_dev = dq_q;
  assign bus.dq_dev_oe = read_active;

  // Single clock here, so the edge choice is only reported outward
  assign active_edge_o = setup_q[EDGE_BIT];
  assign read_setup_o = setup_q;
  assign seq_error_o = seq_err_q;
  assign ident_mode_o = (cmd_state_q == ST_IDENT);

endmodule : flash_setup_dev

// file: design/flash_setup_host.sv
// Purpose: flash controller end, driven by software over Wishbone
// Assumes: classic Wishbone slave, one ack per access
// Notes: reads sample the bus a fixed count after start
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
module flash_setup_host
  import flash_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  flash_bus_if.host bus
);

  typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WRITE, H_READ} hstate_e;

  hstate_e state_q;
  op_e op_q;
  logic step_q;
  logic [3:0] cnt_q;
  logic [15:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] rdata_q;
  logic ack_q;
  logic [31:0] dat_q;
  logic ce_n_q;
  logic oe_n_q;
  logic we_n_q;
  logic adv_n_q;
  logic [15:0] pin_addr_q;
  logic [15:0] pin_dq_q;
  logic pin_dq_oe_q;
  logic wr_req;
  logic start;
  logic [15:0] setup_val;
  logic step_rd;
  logic [15:0] step_addr;
  logic [15:0] step_data;
  logic last_step;

  // Byte-lane merge for the 16-bit registers
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [15:0] r;
    r = old;
    if (sel[0])
    begin
      r[7:0] = dat[7:0];
    end
    if (sel[1])
    begin
      r[15:8] = dat[15:8];
    end
    return r;
  endfunction : merge

  // Clean a setup word before it goes out
  function automatic logic [15:0] fix_setup(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    r[RES14_BIT] = 1'b0;
    r[RES5_BIT] = 1'b0;
    r[RES4_BIT] = 1'b0;
    // Unsupported combination: fall back to wait ending with data
    if (r[LAT_HI:LAT_LO] == LAT_MIN && r[HOLD_BIT])
    begin
      r[WAIT_EARLY_BIT] = 1'b0;
    end
    return r;
  endfunction : fix_setup

  assign wr_req = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q;
  assign start = wr_req && wb_adr_i == HOST_CTRL_OFF && wb_sel_i[0] &&
                 state_q == H_IDLE;
  assign setup_val = fix_setup(addr_q);

  // Step decode for the current operation
  always_comb
  begin
    step_rd = 1'b0;
    step_addr = addr_q;
    step_data = wdata_q;
    last_step = 1'b1;
    case (op_q)
      OP_READ:
      begin
        step_rd = 1'b1;
      end
      OP_CONFIG:
      begin
        // The pair carries the value on the address lines
        step_addr = setup_val;
        step_data = step_q ? {8'h00, CMD_SETUP_LOAD}
                           : {8'h00, CMD_SETUP_PREP};
        last_step = step_q;
      end
      OP_READ_SETUP:
      begin
        step_rd = step_q;
        step_addr = step_q ? IDENT_SETUP_OFFSET : 16'h0000;
        step_data = {8'h00, CMD_READ_IDENT};
        last_step = step_q;
      end
      default:
      begin
        step_rd = 1'b0;
      end
    endcase
  end

  // Software registers; a busy controller ignores a new start
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q <= 16'h0000;
      wdata_q <= 16'h0000;
      op_q <= OP_WRITE;
    end
    else if (wr_req && wb_adr_i == HOST_ADDR_OFF)
    begin
      addr_q <= merge(addr_q, wb_dat_i, wb_sel_i);
    end
    else if (wr_req && wb_adr_i == HOST_WDATA_OFF)
    begin
      wdata_q <= merge(wdata_q, wb_dat_i, wb_sel_i);
    end
    else if (start)
    begin
      op_q <= op_e'(wb_dat_i[1:0]);
    end
  end

  // Bus slave: ack one cycle after the request, then drop
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
      if (wb_adr_i == HOST_ADDR_OFF)
      begin
        dat_q <= {16'h0000, addr_q};
      end
      else if (wb_adr_i == HOST_WDATA_OFF)
      begin
        dat_q <= {16'h0000, wdata_q};
      end
      else if (wb_adr_i == HOST_RDATA_OFF)
      begin
        dat_q <= {16'h0000, rdata_q};
      end
      else if (wb_adr_i == HOST_CTRL_OFF)
      begin
        dat_q <= {30'h0, op_q};
      end
      else if (wb_adr_i == HOST_STATUS_OFF)
      begin
        dat_q <= {31'h0, state_q != H_IDLE};
      end
      else
      begin
        dat_q <= 32'h00000000;
      end
    end
  end

  // Pin sequencer: issue, one-clock write or counted read, then gap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_q <= H_IDLE;
      step_q <= 1'b0;
      cnt_q <= 4'h0;
      rdata_q <= 16'h0000;
      ce_n_q <= 1'b1;
      oe_n_q <= 1'b1;
      we_n_q <= 1'b1;
      adv_n_q <= 1'b1;
      pin_addr_q <= 16'h0000;
      pin_dq_q <= 16'h0000;
      pin_dq_oe_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        H_IDLE:
        begin
          step_q <= 1'b0;
          if (start)
          begin
            state_q <= H_ISSUE;
          end
        end
        H_ISSUE:
        begin
          ce_n_q <= 1'b0;
          pin_addr_q <= step_addr;
          if (step_rd)
          begin
            oe_n_q <= 1'b0;
            adv_n_q <= 1'b0;
            cnt_q <= READ_WAIT_CYC;
            state_q <= H_READ;
          end
          else
          begin
            we_n_q <= 1'b0;
            pin_dq_q <= step_data;
            pin_dq_oe_q <= 1'b1;
            state_q <= H_WRITE;
          end
        end
        default:
        begin
          // H_WRITE and H_READ share the release into the gap
          adv_n_q <= 1'b1;
          if (state_q == H_READ && cnt_q != 4'h0)
          begin
            cnt_q <= cnt_q - 4'h1;
          end
          else
          begin
            if (state_q == H_READ)
            begin
              rdata_q <= bus.dq;
            end
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            pin_dq_oe_q <= 1'b0;
            step_q <= 1'b1;
            state_q <= last_step ? H_IDLE : H_ISSUE;
          end
        end
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign bus.addr = pin_addr_q;
  assign bus.ce_n = ce_n_q;
  assign bus.oe_n = oe_n_q;
  assign bus.we_n = we_n_q;
  assign bus.address_latch_strobe_n = adv_n_q;
  assign bus.dq_host = pin_dq_q;
  assign bus.dq_host_oe = pin_dq_oe_q;

endmodule : flash_setup_host

// file: bench/flash_read_config_register_asserts.sv
// Purpose: pin-level checks on the host/device flash link
// Assumes: one clock, synchronous active-high reset
// Notes: watches the interface pins plus the device setup word
`timescale 1ns/1ps
module flash_read_config_register_asserts
  import flash_cfg_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [15:0] addr,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic address_latch_strobe_n,
  input wire logic [15:0] dq,
  input wire logic wait_line,
  input wire logic [15:0] read_setup_o,
  input wire logic seq_error_o,
  input wire logic ident_mode_o
);
  logic we_n_q;
  logic prep_q;
  logic take;
  logic load;
  logic page;

  // Device only takes a write on a falling we_n
  assign take = !ce_n && !we_n && we_n_q;
  assign load = take && dq[7:0] == CMD_SETUP_LOAD && prep_q;
  assign page = read_setup_o[PROTO_BIT];

  // Previous we_n level
  always_ff @(posedge clk_i)
  begin
    we_n_q <= rst_i ? 1'b1 : we_n;
  end

  // Pending prep command; any later taken write other than another prep ends it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prep_q <= 1'b0;
    else if (take)
      prep_q <= dq[7:0] == CMD_SETUP_PREP;
  end

  // Value the load must store
  function automatic logic [15:0] fix(input logic [15:0] a);
    logic [15:0] r;
    r = a;
    r[RES14_BIT] = 1'b0;
    r[RES5_BIT] = 1'b0;
    r[RES4_BIT] = 1'b0;
    if (r[LAT_HI:LAT_LO] == LAT_MIN && r[HOLD_BIT])
      r[WAIT_EARLY_BIT] = 1'b0;
    return r;
  endfunction : fix

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Burst read: latch, then wait asserted, then released
  sequence s_latch;
    !ce_n && !oe_n && we_n && !address_latch_strobe_n && !page && $past(ce_n);
  endsequence
  sequence s_wait_on;
    wait_line == read_setup_o[WAIT_POL_BIT];
  endsequence
  sequence s_wait_off;
    wait_line != read_setup_o[WAIT_POL_BIT];
  endsequence

  a_reset_word_value: assert property (disable iff (1'b0)
    rst_i |=> read_setup_o == SETUP_RESET)
    else $error("setup word not at reset value");
  a_word_only_load: assert property (
    !$stable(read_setup_o) && !$past(rst_i) |-> $past(load))
    else $error("setup word changed without load pair");
  a_load_stores_addr: assert property (
    load |=> read_setup_o == fix($past(addr)))
    else $error("loaded setup word wrong");
  a_broken_pair_flag: assert property (
    take && prep_q && dq[7:0] != CMD_SETUP_LOAD |=> seq_error_o)
    else $error("broken pair not flagged");
  a_page_wait_idle: assert property (
    page && !ce_n && !oe_n |-> wait_line == !read_setup_o[WAIT_POL_BIT])
    else $error("wait not deasserted in page read");
  a_ident_setup_word: assert property (
    page && ident_mode_o && !ce_n && !oe_n && addr == IDENT_SETUP_OFFSET
    |=> ce_n || dq == read_setup_o)
    else $error("identifier offset five wrong");
  a_array_page_word: assert property (
    page && !ident_mode_o && !prep_q && !ce_n && !oe_n
    |=> ce_n || dq == $past(addr))
    else $error("page array word wrong");
  a_burst_wait_seq: assert property (
    s_latch |-> ##[1:8] s_wait_on ##[1:8] s_wait_off)
    else $error("burst wait sequence missing");
endmodule : flash_read_config_register_asserts

// file: bench/flash_read_config_register_tb.sv
// Purpose: drives software traffic and checks the setup word end to end
// Assumes: host answers each Wishbone access with one ack
// Notes: random words come from a fixed-seed xorshift
`timescale 1ns/1ps
module flash_read_config_register_tb
  import flash_cfg_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_stb = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0;
  logic [3:0] wb_sel = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack;
  logic [15:0] read_setup;
  logic seq_error;
  logic ident_mode;
  logic active_edge;
  logic [31:0] rng = 32'hFEDAF1BF;
  logic [15:0] exp_word;
  logic [15:0] d;
  int n_errors = 0;
  int samples_checked = 0;

  // Free-running 250 MHz clock
  always #2 clk_i = ~clk_i;

  flash_bus_if flash_bus_if_i ();
  flash_setup_dev flash_setup_dev_i (.clk_i(clk_i), .rst_i(rst_i),
    .bus(flash_bus_if_i), .read_setup_o(read_setup),
    .seq_error_o(seq_error), .ident_mode_o(ident_mode),
    .active_edge_o(active_edge));
  flash_setup_host flash_setup_host_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack), .bus(flash_bus_if_i));
  flash_read_config_register_asserts chk_i (.clk_i(clk_i), .rst_i(rst_i),
    .addr(flash_bus_if_i.addr), .ce_n(flash_bus_if_i.ce_n),
    .oe_n(flash_bus_if_i.oe_n), .we_n(flash_bus_if_i.we_n),
    .address_latch_strobe_n(flash_bus_if_i.address_latch_strobe_n),
    .dq(flash_bus_if_i.dq), .wait_line(flash_bus_if_i.wait_line),
    .read_setup_o(read_setup), .seq_error_o(seq_error),
    .ident_mode_o(ident_mode));

  // Fixed-seed xorshift for repeatable stimulus
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs

  // Word the device should hold after loading v
  function automatic logic [15:0] expect_word(input logic [15:0] v);
    logic [15:0] r;
    r = v;
    r[RES14_BIT] = 1'b0;
    r[RES5_BIT] = 1'b0;
    r[RES4_BIT] = 1'b0;
    if (r[LAT_HI:LAT_LO] == LAT_MIN && r[HOLD_BIT])
      r[WAIT_EARLY_BIT] = 1'b0;
    return r;
  endfunction : expect_word

  // Word a fixed-count host read lands on in a linear burst from a
  function automatic logic [15:0] burst_word(input logic [15:0] a,
    input logic [15:0] s);
    logic [15:0] m;
    int lc;
    int k;
    lc = int'(s[LAT_HI:LAT_LO]);
    if (lc < int'(LAT_MIN))
      lc = int'(LAT_MIN);
    // Sample edge is one past the count; first word lands lc after latch
    k = int'(READ_WAIT_CYC) - 1 - lc;
    if (s[HOLD_BIT])
      k = k / 2;
    m = 16'hFFFF;
    if (s[BLEN_HI:BLEN_LO] == BLEN_4)
      m = 16'h0003;
    else if (s[BLEN_HI:BLEN_LO] == BLEN_8)
      m = 16'h0007;
    else if (s[BLEN_HI:BLEN_LO] == BLEN_16)
      m = 16'h000F;
    if (s[WRAP_BIT])
      m = 16'hFFFF;
    return (a & ~m) | ((a + 16'(k)) & m);
  endfunction : burst_word

  task automatic stop_test();
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : stop_test

  task automatic check16(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check16

  task automatic check_bit(input logic got, input logic exp,
    input string what);
    check16({15'h0, got}, {15'h0, exp}, what);
  endtask : check_bit

  // Classic single cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
    input logic [31:0] dt, output logic [31:0] r);
    int n;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= dt;
    wb_sel <= 4'h3;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (wb_ack !== 1'b1 && n < 50);
    r = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    if (wb_ack !== 1'b1)
    begin
      n_errors++;
      stop_test();
    end
  endtask : wb

  // Start an operation and poll busy until it clears
  task automatic run_op(input logic [1:0] op);
    logic [31:0] r;
    int n;
    wb(1'b1, HOST_CTRL_OFF, {30'h0, op}, r);
    for (n = 0; n < 100; n++)
    begin
      wb(1'b0, HOST_STATUS_OFF, 32'h0, r);
      if (r[0] === 1'b0)
        break;
    end
    if (n >= 100)
    begin
      n_errors++;
      stop_test();
    end
  endtask : run_op

  task automatic flash_write(input logic [15:0] a, input logic [7:0] c);
    logic [31:0] r;
    wb(1'b1, HOST_ADDR_OFF, {16'h0, a}, r);
    wb(1'b1, HOST_WDATA_OFF, {24'h0, c}, r);
    run_op(2'd0);
  endtask : flash_write

  task automatic flash_read(input logic [15:0] a, output logic [15:0] q);
    logic [31:0] r;
    wb(1'b1, HOST_ADDR_OFF, {16'h0, a}, r);
    run_op(2'd1);
    wb(1'b0, HOST_RDATA_OFF, 32'h0, r);
    q = r[15:0];
  endtask : flash_read

  // Load a word, then check it in place and read back
  task automatic configure(input logic [15:0] v);
    logic [31:0] r;
    wb(1'b1, HOST_ADDR_OFF, {16'h0, v}, r);
    run_op(2'd2);
    exp_word = expect_word(v);
    check16(read_setup, exp_word, "setup word");
    check_bit(active_edge, exp_word[EDGE_BIT], "edge bit");
    run_op(2'd3);
    wb(1'b0, HOST_RDATA_OFF, 32'h0, r);
    check16(r[15:0], exp_word, "setup readback");
  endtask : configure

  // Main sequence
  initial
  begin
    logic [15:0] v;
    logic [15:0] a;
    logic [31:0] r;
    logic [2:0] bl [4] = '{BLEN_4, BLEN_8, BLEN_16, BLEN_CONT};
    repeat (20) @(posedge clk_i);
    check16(read_setup, SETUP_RESET, "reset word");
    rst_i <= 1'b0;
    configure(16'hFFFF);
    configure(16'h9300);
    for (int i = 0; i < 8; i++)
    begin
      v = 16'(xs());
      v[LAT_HI:LAT_LO] = i[2:0];
      v[BLEN_HI:BLEN_LO] = bl[i % 4];
      v[PROTO_BIT] = 1'b1;
      configure(v);
    end
    for (int i = 0; i < 4; i++)
    begin
      v = 16'(xs());
      v[PROTO_BIT] = 1'b0;
      v[LAT_HI:LAT_LO] = 3'd2 + 3'(i * 2) - 3'(i / 3);
      configure(v);
      flash_write(16'h0000, CMD_READ_ARRAY);
      a = 16'(xs());
      flash_read(a, d);
      check16(d, burst_word(a, exp_word), "burst word");
    end
    configure(v | 16'h8000);
    flash_write(16'h0000, CMD_READ_IDENT);
    flash_read(IDENT_SETUP_OFFSET, d);
    check16(d, exp_word, "ident offset five");
    flash_read(16'h0003, d);
    check16(d, 16'h0000, "ident other offset");
    flash_write(16'h0000, CMD_READ_ARRAY);
    v = 16'(xs());
    flash_read(v, d);
    check16(d, v, "array word");
    flash_write(16'h0000, CMD_SETUP_PREP);
    flash_write(16'h1234, CMD_READ_ARRAY);
    check_bit(seq_error, 1'b1, "broken pair flag");
    check16(read_setup, exp_word, "word after broken pair");
    flash_write(16'h0000, CMD_CLEAR_STATUS);
    check_bit(seq_error, 1'b0, "flag cleared");
    flash_write(16'h0000, CMD_SETUP_LOAD);
    check16(read_setup, exp_word, "lone load ignored");
    wb(1'b1, 8'h14, 32'hFFFF_FFFF, r);
    wb(1'b0, 8'h14, 32'h0, r);
    check16(r[15:0], 16'h0000, "unmapped read");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    check16(read_setup, SETUP_RESET, "word after reset");
    stop_test();
  end
endmodule : flash_read_config_register_tb
